// ===== dtc_params.svh
/*
  Register indices, field positions and reset values for the dual
  timer/event counter. Assumes inclusion by the package only; the core sees the macros through it.
*/
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

`define DTC_IDX_T0_DATA   6'h0d
`define DTC_IDX_T0_CTRL   6'h0e
`define DTC_IDX_T1_HIGH   6'h0f
`define DTC_IDX_T1_LOW    6'h10
`define DTC_IDX_T1_CTRL   6'h11
`define DTC_IDX_IRQ_CTRL  6'h12
`define DTC_CTRL_RESET    8'h08
`define DTC_T1_CTRL_MASK  8'hd8
`define DTC_IRQ_T0_EN     2
`define DTC_IRQ_T1_EN     3
`define DTC_IRQ_T0_FLAG   5
`define DTC_IRQ_T1_FLAG   6
`define DTC_T1_DIV_LAST   2'h3

`endif

// ===== dtc_pkg.sv
/*
  Types shared by the dual timer/event counter.
  Assumes dtc_params.svh sits in the include path.
*/
package dtc_pkg;
  `include "dtc_params.svh"

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_EVT = 2'h1,
    MODE_TMR = 2'h2,
    MODE_PW  = 2'h3
  } dtc_mode_t;

  typedef enum logic [1:0] {
    PW_ARMED = 2'h0,
    PW_MEAS  = 2'h1,
    PW_DONE  = 2'h3
  } dtc_pw_t;

  typedef struct packed {
    dtc_mode_t  mode;
    logic       rsv5;
    logic       count_enable;
    logic       active_edge_select;
    logic [2:0] prescale_select;
  } dtc_ctrl_t;

  typedef struct packed {
    logic [7:0]  t0_cnt;
    logic [7:0]  t0_pre;
    dtc_ctrl_t   t0_ctl;
    logic [7:0]  t0_psc;
    dtc_pw_t     t0_pw;
    logic [15:0] t1_cnt;
    logic [15:0] t1_pre;
    logic [7:0]  t1_buf;
    dtc_ctrl_t   t1_ctl;
    logic [1:0]  t1_div;
    dtc_pw_t     t1_pw;
    logic        t0_flag;
    logic        t1_flag;
    logic        t0_ie;
    logic        t1_ie;
    logic [2:0]  s0;
    logic [2:0]  s1;
    logic [2:0]  rtc_s;
    logic        fdo;
    logic        wake;
    logic        ack;
    logic [7:0]  rdata;
  } dtc_state_t;
endpackage

// ===== dtc_timer.sv
/*
  Dual timer/event counter: an 8-bit counter with prescaler and buzzer
  divider, and a 16-bit counter with a buffered low byte, behind an
  Avalon-MM slave with one wait state. Assumes pins and the RTC clock
  are plain levels, sampled here on i_ref_clk.
*/
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ns
module dtc_timer #(
  parameter bit T0_USE_RTC = 1'b0,
  parameter bit T1_USE_RTC = 1'b0
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_t0_pin,
  input  wire logic        i_t1_pin,
  input  wire logic        i_rtc_clk,
  output logic             o_irq,
  output logic             o_wake,
  output logic             o_freq_divider_output,
  output logic             o_buzzer_output,
  output logic             o_buzzer_output_n
);
  import dtc_pkg::*;

  dtc_state_t r;
  dtc_state_t n;
  logic [5:0] idx;
  logic       wr_now;
  logic       rd_any;
  logic       rtc_tick;
  logic       t0_int;
  logic       t1_int;
  logic       e0_act;
  logic       e0_back;
  logic       e1_act;
  logic       e1_back;
  logic       inc0;
  logic       inc1;
  logic       ov0;
  logic       ov1;
  logic [7:0] wd;

  function automatic logic [7:0] psc_mask(input logic [2:0] p);
    psc_mask = 8'((9'h2 << p) - 9'h1);
  endfunction

  // Edge seen on the second and third sync stages; first stage stays private.
  function automatic logic sel_edge(input logic [2:0] s, input logic fall);
    sel_edge = fall ? (~s[1] & s[2]) : (s[1] & ~s[2]);
  endfunction

  function automatic logic inc_sel(input dtc_ctrl_t c, input logic ext,
                                   input logic tick, input dtc_pw_t pw);
    case (c.mode)
      MODE_EVT: inc_sel = c.count_enable & ext;
      MODE_TMR: inc_sel = c.count_enable & tick;
      MODE_PW:  inc_sel = c.count_enable & tick & (pw == PW_MEAS);
      default:  inc_sel = 1'b0;
    endcase
  endfunction

  assign idx    = i_avs_address[7:2];
  assign wd     = i_avs_writedata[7:0];
  assign wr_now = i_avs_write & r.ack & i_avs_byteenable[0];
  assign rd_any = i_avs_read & ~i_avs_write;

  always_comb begin
    n        = r;
    n.ack    = (i_avs_read | i_avs_write) & ~r.ack;
    n.s0     = {r.s0[1:0], i_t0_pin};
    n.s1     = {r.s1[1:0], i_t1_pin};
    n.rtc_s  = {r.rtc_s[1:0], i_rtc_clk};
    rtc_tick = r.rtc_s[1] & ~r.rtc_s[2];
    // Prescaler runs free on its source; the mask picks the stage.
    n.t0_psc = r.t0_psc + 8'(T0_USE_RTC ? rtc_tick : 1'b1);
    t0_int   = (T0_USE_RTC ? rtc_tick : 1'b1)
               & ((r.t0_psc & psc_mask(r.t0_ctl.prescale_select))
                  == psc_mask(r.t0_ctl.prescale_select));
    n.t1_div = r.t1_div + 2'h1;
    t1_int   = T1_USE_RTC ? rtc_tick : (r.t1_div == `DTC_T1_DIV_LAST);
    e0_act   = sel_edge(r.s0, r.t0_ctl.active_edge_select);
    e0_back  = sel_edge(r.s0, ~r.t0_ctl.active_edge_select);
    e1_act   = sel_edge(r.s1, r.t1_ctl.active_edge_select);
    e1_back  = sel_edge(r.s1, ~r.t1_ctl.active_edge_select);

    // Pulse-width sequencers; the end of a measurement drops the enable.
    case (r.t0_pw)
      PW_ARMED: if (r.t0_ctl.mode == MODE_PW && r.t0_ctl.count_enable && e0_act) begin
        n.t0_pw = PW_MEAS;
      end
      PW_MEAS: if (r.t0_ctl.mode != MODE_PW) begin
        n.t0_pw = PW_ARMED;
      end else if (e0_back) begin
        n.t0_pw               = PW_DONE;
        n.t0_ctl.count_enable = 1'b0;
      end
      PW_DONE: if (r.t0_ctl.count_enable || r.t0_ctl.mode != MODE_PW) begin
        n.t0_pw = PW_ARMED;
      end
      default: n.t0_pw = PW_ARMED;
    endcase
    case (r.t1_pw)
      PW_ARMED: if (r.t1_ctl.mode == MODE_PW && r.t1_ctl.count_enable && e1_act) begin
        n.t1_pw = PW_MEAS;
      end
      PW_MEAS: if (r.t1_ctl.mode != MODE_PW) begin
        n.t1_pw = PW_ARMED;
      end else if (e1_back) begin
        n.t1_pw               = PW_DONE;
        n.t1_ctl.count_enable = 1'b0;
      end
      PW_DONE: if (r.t1_ctl.count_enable || r.t1_ctl.mode != MODE_PW) begin
        n.t1_pw = PW_ARMED;
      end
      default: n.t1_pw = PW_ARMED;
    endcase

    // A read of a live count freezes that counter for the whole access.
    inc0 = inc_sel(r.t0_ctl, e0_act, t0_int, r.t0_pw)
           & ~(rd_any && idx == `DTC_IDX_T0_DATA);
    inc1 = inc_sel(r.t1_ctl, e1_act, t1_int, r.t1_pw)
           & ~(rd_any && idx == `DTC_IDX_T1_HIGH);
    ov0  = inc0 & (r.t0_cnt == 8'hff);
    ov1  = inc1 & (r.t1_cnt == 16'hffff);
    if (ov0) begin
      n.t0_cnt = r.t0_pre;
      n.fdo    = ~r.fdo;
    end else if (inc0) begin
      n.t0_cnt = r.t0_cnt + 8'h01;
    end
    if (ov1) begin
      n.t1_cnt = r.t1_pre;
    end else if (inc1) begin
      n.t1_cnt = r.t1_cnt + 16'h0001;
    end

    if (rd_any && !r.ack) begin
      case (idx)
        `DTC_IDX_T0_DATA:  n.rdata = r.t0_cnt;
        `DTC_IDX_T0_CTRL:  n.rdata = r.t0_ctl & ~8'h20;
        `DTC_IDX_T1_HIGH:  n.rdata = r.t1_cnt[15:8];
        `DTC_IDX_T1_LOW:   n.rdata = r.t1_buf;
        `DTC_IDX_T1_CTRL:  n.rdata = r.t1_ctl & `DTC_T1_CTRL_MASK;
        `DTC_IDX_IRQ_CTRL: n.rdata = {1'b0, r.t1_flag, r.t0_flag, 1'b0,
                                      r.t1_ie, r.t0_ie, 2'h0};
        default:           n.rdata = 8'h00;
      endcase
    end
    if (rd_any && r.ack && idx == `DTC_IDX_T1_HIGH) begin
      n.t1_buf = r.t1_cnt[7:0];
    end

    if (wr_now) begin
      case (idx)
        `DTC_IDX_T0_DATA: begin
          n.t0_pre = wd;
          if (!r.t0_ctl.count_enable) begin
            n.t0_cnt = wd;
          end
        end
        `DTC_IDX_T0_CTRL: begin
          n.t0_ctl      = wd;
          n.t0_ctl.rsv5 = 1'b0;
        end
        `DTC_IDX_T1_HIGH: begin
          n.t1_pre = {wd, r.t1_buf};
          if (!r.t1_ctl.count_enable) begin
            n.t1_cnt = {wd, r.t1_buf};
          end
        end
        `DTC_IDX_T1_LOW:  n.t1_buf = wd;
        `DTC_IDX_T1_CTRL: n.t1_ctl = wd & `DTC_T1_CTRL_MASK;
        `DTC_IDX_IRQ_CTRL: begin
          n.t0_ie   = wd[`DTC_IRQ_T0_EN];
          n.t1_ie   = wd[`DTC_IRQ_T1_EN];
          n.t0_flag = wd[`DTC_IRQ_T0_FLAG];
          n.t1_flag = wd[`DTC_IRQ_T1_FLAG];
        end
        default: ;
      endcase
    end
    // A new overflow beats a clearing write in the same cycle.
    n.t0_flag = n.t0_flag | ov0;
    n.t1_flag = n.t1_flag | ov1;
    n.wake    = ov0 | ov1;
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r        <= '0;
      r.t0_ctl <= `DTC_CTRL_RESET;
      r.t1_ctl <= `DTC_CTRL_RESET;
    end else begin
      r <= n;
    end
  end

  assign o_avs_waitrequest     = (i_avs_read | i_avs_write) & ~r.ack;
  assign o_avs_readdata        = {24'h000000, r.rdata};
  assign o_irq                 = (r.t0_flag & r.t0_ie) | (r.t1_flag & r.t1_ie);
  assign o_wake                = r.wake;
  assign o_freq_divider_output = r.fdo;
  assign o_buzzer_output       = r.fdo;
  assign o_buzzer_output_n     = ~r.fdo;

  ctrl1_reserved_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (r.ack && rd_any && idx == `DTC_IDX_T1_CTRL) |-> (o_avs_readdata[2:0] == 3'h0
      && !o_avs_readdata[5]))
    else $error("timer1 control reserved bits not zero");

  stop_holds_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (!r.t0_ctl.count_enable && !wr_now) |=> (r.t0_cnt == $past(r.t0_cnt)))
    else $error("timer0 counted while disabled");

  low_buffer_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (wr_now && idx == `DTC_IDX_T1_LOW) |=> (r.t1_pre == $past(r.t1_pre)
      && r.t1_buf == $past(wd)))
    else $error("low byte write touched preload");

  high_preload_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (wr_now && idx == `DTC_IDX_T1_HIGH) |=> (r.t1_pre == {$past(wd), $past(r.t1_buf)}))
    else $error("high byte write did not load preload");

  overflow_reload_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (inc1 && r.t1_cnt == 16'hffff && !wr_now) |=> (r.t1_flag
      && r.t1_cnt == $past(r.t1_pre) && o_wake))
    else $error("timer1 overflow did not reload and flag");

  pw_end_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (r.t0_pw == PW_MEAS && r.t0_ctl.mode == MODE_PW && e0_back && !wr_now)
      |=> (!r.t0_ctl.count_enable && r.t0_pw == PW_DONE))
    else $error("pulse end did not clear enable");

  stopped_load_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (wr_now && idx == `DTC_IDX_T0_DATA && !r.t0_ctl.count_enable)
      |=> (r.t0_cnt == $past(wd)))
    else $error("stopped counter missed preload");

  read_block_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (rd_any && idx == `DTC_IDX_T1_HIGH && !r.ack) |=> (r.t1_cnt == $past(r.t1_cnt))
      ##1 (r.t1_buf == $past(r.t1_cnt[7:0], 2)))
    else $error("read did not freeze timer1");

  divider_toggle_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    ov0 |=> (o_freq_divider_output != $past(o_freq_divider_output)
      && o_buzzer_output_n == !o_buzzer_output))
    else $error("divider output missed an overflow");
endmodule // dtc_timer

// ===== dtc_pin_source.sv
/*
  Model of the outside world at the counter pins: the two count/measure
  pins and a slow RTC level. Assumes the bench calls pulse() just after
  a rising edge of i_ref_clk.
*/
`timescale 1ns/1ns
module dtc_pin_source (
  input  wire logic i_ref_clk,
  output logic      o_t0_pin,
  output logic      o_t1_pin,
  output logic      o_rtc_clk
);
  initial begin
    o_t0_pin  = 1'b0;
    o_t1_pin  = 1'b0;
    o_rtc_clk = 1'b0;
  end

  // The RTC runs free and far slower than the system clock.
  always begin
    repeat (50) @(posedge i_ref_clk);
    o_rtc_clk <= ~o_rtc_clk;
  end

  // One high pulse on a pin, then the same time low before returning.
  task automatic pulse(input bit ch, input int hi);
    if (ch) o_t1_pin <= 1'b1; else o_t0_pin <= 1'b1;
    repeat (hi) @(posedge i_ref_clk);
    if (ch) o_t1_pin <= 1'b0; else o_t0_pin <= 1'b0;
    repeat (hi) @(posedge i_ref_clk);
  endtask
endmodule // dtc_pin_source

// ===== tb_dual_timer_event_counter.sv
/*
  Self-checking bench for the dual timer/event counter. Assumes the
  Avalon slave answers after a wait state and dtc_pin_source drives pins.
*/
`timescale 1ns/1ns
module tb_dual_timer_event_counter;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'h1;
  logic [31:0] rdata;
  logic        waitreq, irq, wake, fdo, bz, bz_n, t0_pin, t1_pin, rtc;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          wake_cnt = 0;
  int          n;
  logic [7:0]  q, hi_b;
  logic [15:0] cnt;
  logic [15:0] pw_first;

  always #5 clk = ~clk;
  always @(posedge clk) if (wake === 1'b1) wake_cnt <= wake_cnt + 1;

  dtc_pin_source pins (.i_ref_clk(clk), .o_t0_pin(t0_pin), .o_t1_pin(t1_pin), .o_rtc_clk(rtc));

  dtc_timer dut (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_t0_pin(t0_pin),
    .i_t1_pin(t1_pin), .i_rtc_clk(rtc), .o_irq(irq), .o_wake(wake),
    .o_freq_divider_output(fdo), .o_buzzer_output(bz), .o_buzzer_output_n(bz_n)
  );

  task automatic conclude;
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One Avalon access; the request holds until waitrequest is seen low.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    int k;
    k = 0;
    @(posedge clk);
    rd    <= ~w;
    wr    <= w;
    addr  <= a;
    wdata <= {24'h0, d};
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    r = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 50) begin
      mismatches++;
      conclude();
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] unused;
    acc(1'b1, a, d, unused);
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    acc(1'b0, a, 8'h00, r);
    chk(what, {8'h00, r}, {8'h00, exp});
  endtask

  task automatic rd_t1(output logic [15:0] c);
    logic [7:0] h, l;
    acc(1'b0, 8'h3c, 8'h00, h);
    acc(1'b0, 8'h40, 8'h00, l);
    c = {h, l};
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rchk("t0_ctrl_reset", 8'h38, 8'h08);
    rchk("t1_ctrl_reset", 8'h44, 8'h08);
    wreg(8'h44, 8'hff);
    rchk("t1_ctrl_unused_bits", 8'h44, 8'hd8);
    wreg(8'h44, 8'h08);
    rchk("unmapped_read", 8'h80, 8'h00);
    wreg(8'h34, 8'hfe);
    rchk("t0_stopped_load", 8'h34, 8'hfe);
    // Overflow of timer0 in timer mode with the slowest prescaler.
    wreg(8'h48, 8'h04);
    wreg(8'h38, 8'h97);
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    wreg(8'h38, 8'h07);
    chk("t0_overflow_time", {15'h0, n >= 256 && n <= 530}, 16'h1);
    rchk("irq_flag_set", 8'h48, 8'h24);
    chk("t0_irq_pin", {15'h0, irq}, 16'h1);
    rchk("t0_reloaded_count", 8'h34, 8'hfe);
    chk("wake_pulses", wake_cnt[15:0], 16'h1);
    chk("divider_toggle", {15'h0, fdo}, 16'h1);
    chk("buzzer_pair", {14'h0, bz, bz_n}, 16'h2);
    // A preload write to a running counter must leave the count alone.
    wreg(8'h38, 8'h97);
    wreg(8'h34, 8'h10);
    acc(1'b0, 8'h34, 8'h00, q);
    chk("t0_running_preload", {15'h0, q != 8'h10}, 16'h1);
    wreg(8'h38, 8'h07);
    wreg(8'h48, 8'h20);
    @(posedge clk);
    chk("irq_masked", {15'h0, irq}, 16'h0);
    wreg(8'h48, 8'h00);
    // Timer1 byte pairing through the low-byte buffer.
    wreg(8'h40, 8'h34);
    rd_t1(cnt);
    chk("t1_low_write_only", cnt, 16'h0000);
    // The high read above refilled the buffer, so the low byte goes in again.
    wreg(8'h40, 8'h34);
    wreg(8'h3c, 8'h12);
    rd_t1(cnt);
    chk("t1_high_write_load", cnt, 16'h1234);
    // Event counting on rising edges of the timer1 pin.
    wreg(8'h44, 8'h50);
    repeat (3) pins.pulse(1'b1, 6);
    rchk("t1_enable_kept", 8'h44, 8'h50);
    wreg(8'h44, 8'h40);
    pins.pulse(1'b1, 6);
    rd_t1(cnt);
    chk("t1_event_count", cnt, 16'h1237);
    // Pulse-width measurement: one high pulse of 40 cycles at sysclk/4.
    wreg(8'h44, 8'hd0);
    pins.pulse(1'b1, 40);
    rchk("t1_pw_enable_clear", 8'h44, 8'hc0);
    rd_t1(cnt);
    pw_first = cnt;
    chk("t1_pw_width", {15'h0, cnt >= 16'h1240 && cnt <= 16'h1242}, 16'h1);
    pins.pulse(1'b1, 40);
    rd_t1(cnt);
    chk("t1_pw_held", cnt, pw_first);
    // Falling-edge event counting: one pulse gives exactly one count.
    wreg(8'h44, 8'h58);
    pins.pulse(1'b1, 6);
    rd_t1(cnt);
    chk("t1_falling_edge", cnt, pw_first + 16'h0001);
    conclude();
  end

  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule // tb_dual_timer_event_counter
